// *** core/dcrc_engine.sv ***
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module dcrc_engine (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [31:0] axi_awaddr_i,
   input wire logic axi_awvalid_i,
   output logic axi_awready_o,
   input wire logic [31:0] axi_wdata_i,
   input wire logic [3:0] axi_wstrb_i,
   input wire logic axi_wvalid_i,
   output logic axi_wready_o,
   output logic [1:0] axi_bresp_o,
   output logic axi_bvalid_o,
   input wire logic axi_bready_i,
   input wire logic [31:0] axi_araddr_i,
   input wire logic axi_arvalid_i,
   output logic axi_arready_o,
   output logic [31:0] axi_rdata_o,
   output logic [1:0] axi_rresp_o,
   output logic axi_rvalid_o,
   input wire logic axi_rready_i,
   input wire logic src_valid_i,
   output logic src_ready_o,
   input wire logic [2:0] src_chan_i,
   input wire logic [31:0] src_data_i,
   input wire logic src_last_i,
   output logic dst_valid_o,
   input wire logic dst_ready_i,
   output logic [31:0] dst_data_o,
   output logic [2:0] dst_chan_o,
   output logic dst_result_o
);
   // -----------------------------
   // registers and fields
   // -----------------------------
   logic [31:0] ctrl_r;
   logic [31:0] taps_r;
   logic [1:0] byte_order_sel;
   logic write_reorder_en;
   logic reflect_sel;
   logic [4:0] poly_len_minus_one;
   logic engine_route_en;
   logic append_result_mode;
   logic checksum_type_sel;
   logic [2:0] assigned_channel_sel;
   logic [31:0] value_rd;
   logic [31:0] sw_data;

   assign byte_order_sel = ctrl_r[dcrc_pkg::BYTO_LO +: 2];
   assign write_reorder_en = ctrl_r[dcrc_pkg::WBO_BIT];
   assign reflect_sel = ctrl_r[dcrc_pkg::REFLECT_SEL_BIT];
   assign poly_len_minus_one = ctrl_r[dcrc_pkg::PLEN_LO +: 5];
   assign engine_route_en = ctrl_r[dcrc_pkg::EN_BIT];
   assign append_result_mode = ctrl_r[dcrc_pkg::APP_BIT];
   assign checksum_type_sel = ctrl_r[dcrc_pkg::TYP_BIT];
   assign assigned_channel_sel = ctrl_r[dcrc_pkg::CH_LO +: 3];

   dcrc_calc_if cif ();

   dcrc_swap dcrc_swap_inst (
      .sel_i(byte_order_sel),
      .data_i(src_data_i),
      .data_o(sw_data)
   );

   dcrc_calc dcrc_calc_inst (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .cif(cif)
   );

   // formatted view of the generator
   always_comb begin
      if (checksum_type_sel) begin
         value_rd = {16'h0, ~cif.value[15:0]};
      end else begin
         value_rd = cif.value & dcrc_pkg::poly_mask(poly_len_minus_one);
      end
   end

   // -----------------------------
   // axi4-lite slave
   // -----------------------------
   logic aw_hold_r;
   logic w_hold_r;
   logic [31:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic arready_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic wr_fire;
   logic b_done;
   logic [31:0] bmask;
   logic [31:0] ctrl_new;
   logic seed_wr;
   logic [31:0] seed_val;

   assign wr_fire = aw_hold_r & w_hold_r & ~bvalid_r;
   assign b_done = bvalid_r & axi_bready_i;
   assign bmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
   assign ctrl_new = ((ctrl_r & ~bmask) | (wdata_r & bmask)) & dcrc_pkg::CTRL_IMPL;
   assign seed_wr = wr_fire & (awaddr_r == dcrc_pkg::OFS_DATA);
   assign seed_val = (value_rd & ~bmask) | (wdata_r & bmask);

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         aw_hold_r <= 1'b0;
         awready_r <= 1'b1;
         awaddr_r <= 32'h0;
      end else if (axi_awvalid_i && awready_r) begin
         aw_hold_r <= 1'b1;
         awready_r <= 1'b0;
         awaddr_r <= axi_awaddr_i;
      end else if (b_done) begin
         aw_hold_r <= 1'b0;
         awready_r <= 1'b1;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         w_hold_r <= 1'b0;
         wready_r <= 1'b1;
         wdata_r <= 32'h0;
         wstrb_r <= 4'h0;
      end else if (axi_wvalid_i && wready_r) begin
         w_hold_r <= 1'b1;
         wready_r <= 1'b0;
         wdata_r <= axi_wdata_i;
         wstrb_r <= axi_wstrb_i;
      end else if (b_done) begin
         w_hold_r <= 1'b0;
         wready_r <= 1'b1;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         bvalid_r <= 1'b0;
         bresp_r <= dcrc_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_r <= 1'b1;
         if (awaddr_r == dcrc_pkg::OFS_CTRL || awaddr_r == dcrc_pkg::OFS_DATA ||
             awaddr_r == dcrc_pkg::OFS_TAPS) begin
            bresp_r <= dcrc_pkg::RESP_OKAY;
         end else begin
            bresp_r <= dcrc_pkg::RESP_SLVERR;
         end
      end else if (b_done) begin
         bvalid_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         ctrl_r <= dcrc_pkg::RST_CTRL;
      end else if (wr_fire && awaddr_r == dcrc_pkg::OFS_CTRL) begin
         ctrl_r <= ctrl_new;
         // append cannot stick while reorder is on
         if (ctrl_new[dcrc_pkg::WBO_BIT]) begin
            ctrl_r[dcrc_pkg::APP_BIT] <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         taps_r <= dcrc_pkg::RST_TAPS;
      end else if (wr_fire && awaddr_r == dcrc_pkg::OFS_TAPS) begin
         taps_r <= (taps_r & ~bmask) | (wdata_r & bmask);
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0;
         rresp_r <= dcrc_pkg::RESP_OKAY;
      end else if (axi_arvalid_i && arready_r) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rresp_r <= dcrc_pkg::RESP_OKAY;
         case (axi_araddr_i)
            dcrc_pkg::OFS_CTRL: rdata_r <= ctrl_r;
            dcrc_pkg::OFS_DATA: rdata_r <= value_rd;
            dcrc_pkg::OFS_TAPS: rdata_r <= taps_r;
            default: begin
               rdata_r <= 32'h0;
               rresp_r <= dcrc_pkg::RESP_SLVERR;
            end
         endcase
      end else if (rvalid_r && axi_rready_i) begin
         rvalid_r <= 1'b0;
         arready_r <= 1'b1;
      end
   end

   assign axi_awready_o = awready_r;
   assign axi_wready_o = wready_r;
   assign axi_bvalid_o = bvalid_r;
   assign axi_bresp_o = bresp_r;
   assign axi_arready_o = arready_r;
   assign axi_rvalid_o = rvalid_r;
   assign axi_rdata_o = rdata_r;
   assign axi_rresp_o = rresp_r;

   // -----------------------------
   // data path
   // -----------------------------
   dcrc_pkg::dcrc_state_t st_r;
   logic src_ready_r;
   logic dst_valid_r;
   logic [31:0] dst_data_r;
   logic [2:0] dst_chan_r;
   logic dst_result_r;
   logic acc;
   logic routed;
   logic absorb;

   assign acc = src_valid_i & src_ready_r;
   assign routed = engine_route_en & (src_chan_i == assigned_channel_sel);
   assign absorb = routed & append_result_mode;

   // software seed wins over a stream word in the same cycle
   assign cif.step = acc & routed;
   assign cif.din = sw_data;
   assign cif.seed_wr = seed_wr;
   assign cif.seed = seed_val;
   assign cif.reflect = reflect_sel;
   assign cif.cksum = checksum_type_sel;
   assign cif.plen = poly_len_minus_one;
   assign cif.taps = taps_r;

   // one word in flight; ready drops while the output holds
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         st_r <= dcrc_pkg::ST_IDLE;
         src_ready_r <= 1'b0;
         dst_valid_r <= 1'b0;
         dst_data_r <= 32'h0;
         dst_chan_r <= 3'h0;
         dst_result_r <= 1'b0;
      end else begin
         case (st_r)
            dcrc_pkg::ST_IDLE: begin
               src_ready_r <= 1'b1;
               if (acc && absorb) begin
                  if (src_last_i) begin
                     st_r <= dcrc_pkg::ST_PEND;
                     src_ready_r <= 1'b0;
                     dst_chan_r <= src_chan_i;
                  end
               end else if (acc) begin
                  st_r <= dcrc_pkg::ST_OUT;
                  src_ready_r <= 1'b0;
                  dst_valid_r <= 1'b1;
                  dst_chan_r <= src_chan_i;
                  dst_result_r <= 1'b0;
                  if (routed && write_reorder_en) begin
                     dst_data_r <= sw_data;
                  end else begin
                     dst_data_r <= src_data_i;
                  end
               end
            end
            dcrc_pkg::ST_PEND: begin
               // generator already holds the last word here
               st_r <= dcrc_pkg::ST_OUT;
               dst_valid_r <= 1'b1;
               dst_data_r <= value_rd;
               dst_result_r <= 1'b1;
            end
            dcrc_pkg::ST_OUT: begin
               if (dst_ready_i) begin
                  st_r <= dcrc_pkg::ST_IDLE;
                  dst_valid_r <= 1'b0;
                  dst_result_r <= 1'b0;
                  src_ready_r <= 1'b1;
               end
            end
            default: begin
               st_r <= dcrc_pkg::ST_IDLE;
               dst_valid_r <= 1'b0;
               src_ready_r <= 1'b0;
            end
         endcase
      end
   end

   assign src_ready_o = src_ready_r;
   assign dst_valid_o = dst_valid_r;
   assign dst_data_o = dst_data_r;
   assign dst_chan_o = dst_chan_r;
   assign dst_result_o = dst_result_r;

   // -----------------------------
   // assertions
   // -----------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   logic rd_data_q;
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         rd_data_q <= 1'b0;
      end else if (axi_arvalid_i && arready_r) begin
         rd_data_q <= (axi_araddr_i == dcrc_pkg::OFS_DATA);
      end
   end

   no_app_wbo_a: assert property (
      !(ctrl_r[dcrc_pkg::APP_BIT] && ctrl_r[dcrc_pkg::WBO_BIT]))
      else $error("append set while reorder set");
   ck_upper_a: assert property (
      rvalid_r && rd_data_q && checksum_type_sel |-> rdata_r[31:16] == 16'h0)
      else $error("checksum read upper half not zero");
   lfsr_mask_a: assert property (
      $rose(rvalid_r) && rd_data_q && !checksum_type_sel && $stable(ctrl_r)
      |-> (rdata_r & ~dcrc_pkg::poly_mask(poly_len_minus_one)) == 32'h0)
      else $error("lfsr read has bits above length");
   pass_raw_a: assert property (
      acc && !routed |=> dst_valid_r && dst_data_r == $past(src_data_i) && !dst_result_r)
      else $error("unrouted word altered");
   reorder_a: assert property (
      acc && routed && !append_result_mode |=>
      dst_data_r == (write_reorder_en ? $past(sw_data) : $past(src_data_i)))
      else $error("destination order wrong");
   app_hold_a: assert property (
      acc && absorb && !src_last_i |=> !dst_valid_r && src_ready_r)
      else $error("append word reached destination");
   app_result_a: assert property (
      acc && absorb && src_last_i |-> ##2 dst_valid_r && dst_result_r && dst_data_r == value_rd)
      else $error("append result missing");
   seed_load_a: assert property (
      seed_wr && !checksum_type_sel |=> cif.value == $past(seed_val))
      else $error("seed not loaded");
   seed_ck_a: assert property (
      seed_wr && checksum_type_sel |=> cif.value[15:0] == ~$past(seed_val[15:0]))
      else $error("checksum seed not converted");
   wr_resp_a: assert property (
      wr_fire |=> bvalid_r [*1] ##0 !awready_r && !wready_r)
      else $error("write response late");

   cov_append_c: cover property (acc && absorb && src_last_i ##2 dst_result_r);
   cov_pass_c: cover property (acc && !routed ##1 dst_valid_r && dst_ready_i);
   cov_ck_rd_c: cover property (rvalid_r && rd_data_q && checksum_type_sel);
endmodule : dcrc_engine

// *** common/dcrc_pkg.sv ***
package dcrc_pkg;
   // -----------------------------
   // register map
   // -----------------------------
   localparam logic [31:0] OFS_CTRL = 32'h0000_0000;
   localparam logic [31:0] OFS_DATA = 32'h0000_0004;
   localparam logic [31:0] OFS_TAPS = 32'h0000_0008;
   localparam logic [31:0] RST_CTRL = 32'h0000_0000;
   localparam logic [31:0] RST_TAPS = 32'h0000_0000;
   localparam logic [31:0] RST_SEED = 32'h0000_0000;
   // -----------------------------
   // control fields
   // -----------------------------
   localparam int BYTO_LO = 28;
   localparam int WBO_BIT = 27;
   localparam int REFLECT_SEL_BIT = 24;
   localparam int PLEN_LO = 8;
   localparam int EN_BIT = 7;
   localparam int APP_BIT = 6;
   localparam int TYP_BIT = 5;
   localparam int CH_LO = 0;
   localparam logic [31:0] CTRL_IMPL = 32'h3900_1fe7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // -----------------------------
   // stream states
   // -----------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_PEND = 3'h2,
      ST_OUT = 3'h4
   } dcrc_state_t;

   // ones in the low plen+1 bits
   function automatic logic [31:0] poly_mask(input logic [4:0] plen);
      poly_mask = 32'hffff_ffff >> (5'h1f - plen);
   endfunction : poly_mask
endpackage : dcrc_pkg

// *** common/dcrc_calc_if.sv ***
`timescale 1ns/1ps
interface dcrc_calc_if;
   logic step;
   logic [31:0] din;
   logic seed_wr;
   logic [31:0] seed;
   logic reflect;
   logic cksum;
   logic [4:0] plen;
   logic [31:0] taps;
   logic [31:0] value;
   modport host (output step, din, seed_wr, seed, reflect, cksum, plen, taps,
                 input value);
   modport calc (input step, din, seed_wr, seed, reflect, cksum, plen, taps,
                 output value);
endinterface : dcrc_calc_if

// *** core/dcrc_swap.sv ***
`timescale 1ns/1ps
module dcrc_swap (
   input wire logic [1:0] sel_i,
   input wire logic [31:0] data_i,
   output logic [31:0] data_o
);
   always_comb begin
      case (sel_i)
         2'h0: data_o = data_i;
         2'h1: data_o = {data_i[7:0], data_i[15:8], data_i[23:16], data_i[31:24]};
         2'h2: data_o = {data_i[15:0], data_i[31:16]};
         default: data_o = {data_i[23:16], data_i[31:24], data_i[7:0], data_i[15:8]};
      endcase
   end
endmodule : dcrc_swap

// *** core/dcrc_calc.sv ***
`timescale 1ns/1ps
module dcrc_calc (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   dcrc_calc_if.calc cif
);
   logic [31:0] state_r;
   logic [31:0] state_nxt;
   logic [31:0] lfsr;
   logic [31:0] msk;
   logic [31:0] d;
   logic [17:0] sum;
   logic fb;

   assign cif.value = state_r;

   always_comb begin
      fb = 1'b0;
      msk = dcrc_pkg::poly_mask(cif.plen);
      lfsr = state_r;
      d = cif.din;
      // whole word per cycle, one bit per loop pass
      for (int i = 0; i < 32; i++) begin
         fb = lfsr[cif.plen] ^ (cif.reflect ? cif.din[i] : cif.din[31-i]);
         lfsr = ((lfsr << 1) ^ (fb ? cif.taps : 32'h0)) & msk;
      end
      if (cif.reflect) begin
         d = {<<{cif.din}};
      end
      sum = {2'h0, state_r[15:0]} + {2'h0, d[31:16]} + {2'h0, d[15:0]};
      sum = {2'h0, sum[15:0]} + {16'h0, sum[17:16]};
      sum = {2'h0, sum[15:0]} + {16'h0, sum[17:16]};
      state_nxt = state_r;
      if (cif.seed_wr) begin
         state_nxt = cif.cksum ? {16'h0, ~cif.seed[15:0]} : cif.seed;
      end else if (cif.step) begin
         state_nxt = cif.cksum ? {16'h0, sum[15:0]} : lfsr;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         state_r <= dcrc_pkg::RST_SEED;
      end else begin
         state_r <= state_nxt;
      end
   end
endmodule : dcrc_calc

// *** sim/dcrc_dma_model.sv ***
`timescale 1ns/1ps
module dcrc_dma_model (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   output logic src_valid_o,
   input wire logic src_ready_i,
   output logic [2:0] src_chan_o,
   output logic [31:0] src_data_o,
   output logic src_last_o,
   input wire logic dst_valid_i,
   output logic dst_ready_o,
   input wire logic [31:0] dst_data_i,
   input wire logic [2:0] dst_chan_i,
   input wire logic dst_result_i
);
   int stall = 0;
   int wait_cnt = 0;
   logic [35:0] dst_q[$];

   initial begin
      src_valid_o = 1'b0;
      src_chan_o = 3'h0;
      src_data_o = 32'h0;
      src_last_o = 1'b0;
      dst_ready_o = 1'b1;
   end

   // -----------------------------
   // source side
   // -----------------------------
   task automatic send(input logic [31:0] d, input logic [2:0] ch, input logic last);
      @(posedge mclk_i);
      src_valid_o <= 1'b1;
      src_data_o <= d;
      src_chan_o <= ch;
      src_last_o <= last;
      do @(posedge mclk_i); while (src_ready_i !== 1'b1);
      src_valid_o <= 1'b0;
      // released data flips so a stale word never looks valid
      src_data_o <= ~d;
      src_last_o <= ~last;
   endtask : send

   // -----------------------------
   // destination side
   // -----------------------------
   always @(posedge mclk_i) begin
      if (dst_valid_i && dst_ready_o) begin
         dst_q.push_back({dst_result_i, dst_chan_i, dst_data_i});
         wait_cnt <= 0;
         dst_ready_o <= (stall == 0);
      end else begin
         if (dst_valid_i) begin
            wait_cnt <= wait_cnt + 1;
         end
         dst_ready_o <= (stall == 0) || (dst_valid_i && wait_cnt + 1 >= stall);
      end
   end
endmodule : dcrc_dma_model

// *** sim/dma_crc_checksum_engine_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module dma_crc_checksum_engine_tb_top;
   typedef struct packed {
      logic [31:0] ctrl;
      logic [2:0] ch;
      logic [31:0] din;
      logic [31:0] dout;
   } dcrc_row_t;
   localparam dcrc_row_t ROWS [0:6] = '{
      '{32'h1800_0083, 3'h3, 32'h1122_3344, 32'h4433_2211},
      '{32'h2800_0083, 3'h3, 32'h1122_3344, 32'h3344_1122},
      '{32'h3800_0083, 3'h3, 32'h1122_3344, 32'h2211_4433},
      '{32'h0800_0083, 3'h3, 32'h1122_3344, 32'h1122_3344},
      '{32'h1000_0083, 3'h3, 32'h1122_3344, 32'h1122_3344},
      '{32'h1800_0083, 3'h5, 32'h1122_3344, 32'h1122_3344},
      '{32'h1800_0003, 3'h3, 32'h1122_3344, 32'h1122_3344}};
   localparam logic [31:0] TAPS = 32'h04c1_1db7;
   logic mclk_i = 1'b0, rst_n_i = 1'b0;
   logic [31:0] aw_a = 32'h0, w_d = 32'h0, ar_a = 32'h0;
   logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
   logic [3:0] w_s = 4'hf;
   logic awr, wr, bv, arr, rv, sv, sr, sl, dv, dr, dres;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, sd, dd;
   logic [2:0] sch, dch;
   int n_fail = 0, n_compared = 0, cyc = 0;

   dcrc_engine dcrc_engine_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
      .axi_awaddr_i(aw_a), .axi_awvalid_i(awv), .axi_awready_o(awr),
      .axi_wdata_i(w_d), .axi_wstrb_i(w_s), .axi_wvalid_i(wv), .axi_wready_o(wr),
      .axi_bresp_o(bresp), .axi_bvalid_o(bv), .axi_bready_i(bre),
      .axi_araddr_i(ar_a), .axi_arvalid_i(arv), .axi_arready_o(arr),
      .axi_rdata_o(rdata), .axi_rresp_o(rresp), .axi_rvalid_o(rv), .axi_rready_i(rre),
      .src_valid_i(sv), .src_ready_o(sr), .src_chan_i(sch), .src_data_i(sd),
      .src_last_i(sl), .dst_valid_o(dv), .dst_ready_i(dr), .dst_data_o(dd),
      .dst_chan_o(dch), .dst_result_o(dres));
   dcrc_dma_model dcrc_dma_model_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
      .src_valid_o(sv), .src_ready_i(sr), .src_chan_o(sch), .src_data_o(sd),
      .src_last_o(sl), .dst_valid_i(dv), .dst_ready_o(dr), .dst_data_i(dd),
      .dst_chan_i(dch), .dst_result_i(dres));

   initial begin
      forever #25 mclk_i = ~mclk_i;
   end

   // -----------------------------
   // run control
   // -----------------------------
   task automatic wrap_up();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : wrap_up

   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         $display("CHECK FAILED t=%0t run too long", $time);
         wrap_up();
      end
   end

   // -----------------------------
   // bus and stream helpers
   // -----------------------------
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge mclk_i);
      awv <= 1'b1;
      aw_a <= a;
      wv <= 1'b1;
      w_d <= d;
      bre <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge mclk_i);
         if (awv && awr === 1'b1) begin
            aw_ok = 1'b1;
            awv <= 1'b0;
         end
         if (wv && wr === 1'b1) begin
            w_ok = 1'b1;
            wv <= 1'b0;
         end
      end
      do @(posedge mclk_i); while (bv !== 1'b1);
      r = bresp;
      bre <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge mclk_i);
      arv <= 1'b1;
      ar_a <= a;
      rre <= 1'b1;
      do @(posedge mclk_i); while (arr !== 1'b1);
      arv <= 1'b0;
      do @(posedge mclk_i); while (rv !== 1'b1);
      d = rdata;
      r = rresp;
      rre <= 1'b0;
   endtask : axi_rd

   task automatic wreg(input logic [31:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_wr(a, d, r);
      `CHK(r, dcrc_pkg::RESP_OKAY)
   endtask : wreg

   task automatic chk_reg(input logic [31:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(a, d, r);
      `CHK(d, e)
      `CHK(r, dcrc_pkg::RESP_OKAY)
   endtask : chk_reg

   task automatic pop_dst(output logic [35:0] v);
      int k;
      k = 0;
      while (dcrc_dma_model_inst.dst_q.size() == 0 && k < 200) begin
         @(posedge mclk_i);
         k++;
      end
      if (dcrc_dma_model_inst.dst_q.size() == 0) begin
         n_fail++;
         $display("CHECK FAILED t=%0t no destination word", $time);
         v = 'x;
      end else v = dcrc_dma_model_inst.dst_q.pop_front();
   endtask : pop_dst

   task automatic chk_rst();
      chk_reg(dcrc_pkg::OFS_CTRL, dcrc_pkg::RST_CTRL);
      chk_reg(dcrc_pkg::OFS_DATA, dcrc_pkg::RST_SEED);
      chk_reg(dcrc_pkg::OFS_TAPS, dcrc_pkg::RST_TAPS);
   endtask : chk_rst

   // -----------------------------
   // reference arithmetic
   // -----------------------------
   function automatic logic [31:0] arr_w(input logic [1:0] s, input logic [31:0] d);
      case (s)
         2'h1: return {d[7:0], d[15:8], d[23:16], d[31:24]};
         2'h2: return {d[15:0], d[31:16]};
         2'h3: return {d[23:16], d[31:24], d[7:0], d[15:8]};
         default: return d;
      endcase
   endfunction : arr_w

   function automatic logic [31:0] lfsr(input logic [31:0] st, input logic [31:0] w,
                                        input logic [4:0] p, input logic rf);
      logic [31:0] m;
      logic fb;
      m = 32'hffff_ffff >> (5'h1f - p);
      for (int i = 0; i < 32; i++) begin
         fb = st[p] ^ (rf ? w[i] : w[31 - i]);
         st = ((st << 1) ^ (fb ? TAPS : 32'h0)) & m;
      end
      return st & m;
   endfunction : lfsr

   function automatic logic [15:0] csum(input logic [15:0] s, input logic [31:0] w);
      logic [17:0] a;
      a = s + w[31:16] + w[15:0];
      a = a[15:0] + a[17:16];
      return a[15:0] + 16'(a[16]);
   endfunction : csum

   // -----------------------------
   // main sequence
   // -----------------------------
   initial begin
      logic [31:0] d, w, rw, st;
      logic [1:0] r;
      logic [35:0] v;
      logic [4:0] p;
      logic [15:0] cs;
      repeat (16) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      chk_rst();
      // reorder set in the same write must veto append
      wreg(dcrc_pkg::OFS_CTRL, 32'hffff_ffff);
      chk_reg(dcrc_pkg::OFS_CTRL, 32'h3900_1fa7);
      axi_wr(32'h0000_000c, 32'h5a5a_5a5a, r);
      `CHK(r, dcrc_pkg::RESP_SLVERR)
      axi_rd(32'h0000_000c, d, r);
      `CHK({r, d}, {dcrc_pkg::RESP_SLVERR, 32'h0})
      // byte-lane write of append alone while reorder stays set
      w_s <= 4'h1;
      wreg(dcrc_pkg::OFS_CTRL, 32'h0000_0040);
      w_s <= 4'hf;
      chk_reg(dcrc_pkg::OFS_CTRL, 32'h3900_1f00);
      $display("test registers done");
      foreach (ROWS[i]) begin
         wreg(dcrc_pkg::OFS_CTRL, ROWS[i].ctrl);
         dcrc_dma_model_inst.send(ROWS[i].din, ROWS[i].ch, 1'b1);
         pop_dst(v);
         `CHK(v, {1'b0, ROWS[i].ch, ROWS[i].dout})
      end
      $display("test byte order done");
      dcrc_dma_model_inst.stall = 2;
      wreg(dcrc_pkg::OFS_TAPS, TAPS);
      for (int c = 0; c < 8; c++) begin
         p = 5'(4 * c + 3);
         w = 32'hc3a5_0f96 ^ (32'h0101_0101 * 32'(c));
         wreg(dcrc_pkg::OFS_CTRL, {2'h0, 2'(c >> 1), 3'h0, 1'(c), 11'h0, p, 8'h80 | 8'(c)});
         wreg(dcrc_pkg::OFS_DATA, 32'hffff_ffff);
         chk_reg(dcrc_pkg::OFS_DATA, 32'hffff_ffff >> (5'h1f - p));
         dcrc_dma_model_inst.send(w, 3'(c + 1), 1'b0);
         pop_dst(v);
         `CHK(v, {1'b0, 3'(c + 1), w})
         dcrc_dma_model_inst.send(w, 3'(c), 1'b0);
         pop_dst(v);
         `CHK(v, {1'b0, 3'(c), w})
         st = lfsr(32'hffff_ffff, arr_w(2'(c >> 1), w), p, 1'(c));
         chk_reg(dcrc_pkg::OFS_DATA, st);
      end
      $display("test lfsr done");
      for (int rf = 0; rf < 2; rf++) begin
         wreg(dcrc_pkg::OFS_CTRL, {7'h0, 1'(rf), 11'h0, 5'h1f, 8'ha2});
         wreg(dcrc_pkg::OFS_DATA, 32'habcd_1234);
         chk_reg(dcrc_pkg::OFS_DATA, 32'h0000_1234);
         wreg(dcrc_pkg::OFS_DATA, 32'h0);
         cs = 16'hffff;
         for (int k = 0; k < 2; k++) begin
            w = (k == 1) ? 32'h1c46_4000 : 32'h4500_003c;
            dcrc_dma_model_inst.send(w, 3'h2, 1'b0);
            pop_dst(v);
            `CHK(v, {1'b0, 3'h2, w})
            rw = {<<{w}};
            cs = csum(cs, (rf == 1) ? rw : w);
         end
         chk_reg(dcrc_pkg::OFS_DATA, {16'h0, ~cs});
      end
      $display("test checksum done");
      dcrc_dma_model_inst.stall = 3;
      wreg(dcrc_pkg::OFS_CTRL, 32'h0000_1fc1);
      chk_reg(dcrc_pkg::OFS_CTRL, 32'h0000_1fc1);
      wreg(dcrc_pkg::OFS_DATA, 32'hffff_ffff);
      st = 32'hffff_ffff;
      for (int k = 0; k < 3; k++) begin
         w = 32'h1357_9bdf + 32'(k);
         dcrc_dma_model_inst.send(w, 3'h1, k == 2);
         st = lfsr(st, w, 5'h1f, 1'b0);
      end
      pop_dst(v);
      `CHK(v, {1'b1, 3'h1, st})
      repeat (10) @(posedge mclk_i);
      `CHK(dcrc_dma_model_inst.dst_q.size(), 0)
      $display("test append done");
      @(posedge mclk_i);
      rst_n_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      chk_rst();
      $display("test second reset done");
      wrap_up();
   end
endmodule : dma_crc_checksum_engine_tb_top
